// ---- rtl/fpsc_pkg.sv ----
// constants, field layouts and carrier types for the floating store/convert unit
package fpsc_pkg;

    // register byte addresses on the apb slave
    localparam logic [7:0] ADDR_FPS = 8'h00;
    localparam logic [7:0] ADDR_FEC = 8'h04;
    localparam logic [7:0] ADDR_FEA = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h14;
    localparam logic [7:0] ADDR_CONFIG = 8'h18;

    // float_status_register field positions, and the config_reg maintenance bit
    localparam int FPS_FC = 0;
    localparam int FPS_FV = 1;
    localparam int FPS_FZ = 2;
    localparam int FPS_FN = 3;
    localparam int FPS_FMM = 4;
    localparam int FPS_FT = 5;
    localparam int FPS_FL = 6;
    localparam int FPS_FD = 7;
    localparam int FPS_FIC = 8;
    localparam int FPS_UNDEFINED_VALUE_TRAP_ENABLE = 11;
    localparam int FPS_HOLE_LO = 12;
    localparam int FPS_HOLE_HI = 13;
    localparam int CFG_MAINT_IMPL = 0;

    localparam logic [15:0] FPS_RESET = 16'h0000;
    localparam logic [15:0] FEC_RESET = 16'h0000;
    localparam logic [15:0] FEA_RESET = 16'h0000;
    localparam logic [15:0] CONFIG_RESET = 16'h0000;
    localparam logic [15:0] FEC_CONVERT_FAIL = 16'h0006;

    // interrupt status bits
    localparam int IRQ_CONVERT_FAIL = 0;
    localparam int IRQ_TRAP = 1;
    localparam int IRQ_DONE = 2;
    localparam int IRQ_W = 3;

    // opcode fields
    localparam logic [7:0] OP_STORE_EXPONENT_OP = 8'hFA;
    localparam logic [7:0] OP_STCXJ = 8'hFB;
    localparam logic [9:0] OP_STORE_FLOAT_STATUS_OP = 10'h3C2;
    localparam logic [9:0] OP_STORE_EXCEPTION_INFO_OP = 10'h3C3;
    localparam logic [5:0] DST_IMMEDIATE = 6'h17;

    // exponent arithmetic
    localparam logic [15:0] EXP_BIAS = 16'h0080;
    localparam logic [7:0] EXP_INT_MIN = 8'h80;
    localparam logic [7:0] EXP_INT_MAX = 8'hA0;
    localparam logic [7:0] SHIFT_BASE = 8'hB8;

    // largest_integer_limit per mode
    localparam logic [32:0] INT_LIMIT = 33'h0_0000_7FFF;
    localparam logic [32:0] LONG_LIMIT = 33'h0_7FFF_FFFF;
    localparam logic [32:0] ONE_33 = 33'h0_0000_0001;

    localparam logic [1:0] WORD_OFFSET_FIRST = 2'h0;
    localparam logic [1:0] WORD_OFFSET_NEXT = 2'h2;

    typedef struct packed {
        logic sign;
        logic [7:0] exp;
        logic [54:0] frac;
    } acc_t;

    typedef struct packed {
        logic valid;
        logic last;
        logic [1:0] offset;
        logic [15:0] data;
    } store_word_t;

    typedef struct packed {
        logic n;
        logic z;
        logic v;
        logic c;
    } cc_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SECOND = 2'b10
    } state_t;

endpackage

// ---- rtl/fp_store_convert_unit.sv ----
// floating store instructions: float to integer, store exponent, store status, store exception info
//
// Decided for this implementation: the address map and the APB interface to the registers.
module fp_store_convert_unit
    import fpsc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // instruction from the core
    input wire logic issue,
    input wire logic [15:0] instr,
    input wire logic [15:0] instr_addr,
    input wire acc_t acc_in,
    // destination writes and results to the core
    output store_word_t st_word,
    output cc_t cc_out,
    output logic cc_valid,
    output logic busy,
    output logic fp_trap,
    output logic irq
);

    state_t state_reg;
    store_word_t st_word_reg;
    logic [15:0] pend_data_reg;
    logic [15:0] fps_reg;
    logic [15:0] fec_reg;
    logic [15:0] fea_reg;
    logic [15:0] config_reg;
    logic [IRQ_W-1:0] irq_status_reg;
    logic [IRQ_W-1:0] irq_enable_reg;
    logic irq_reg;
    cc_t cc_out_reg;
    logic cc_valid_reg;
    logic fp_trap_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;

    logic accept;
    logic is_conv;
    logic is_store_exponent_op;
    logic is_store_float_status_op;
    logic is_store_exception_info_op;
    logic dst_short;
    acc_t acc_eff;
    logic [55:0] mant;
    logic [7:0] shift_amt;
    logic [55:0] shifted;
    logic [32:0] mag;
    logic [32:0] limit;
    logic oor;
    logic [31:0] conv_val;
    logic conv_neg;
    logic [15:0] exp_val;
    logic exp_neg;
    logic [15:0] fps_stored;
    logic apb_setup;
    logic apb_take;
    logic apb_wr;
    logic [IRQ_W-1:0] irq_events;
    logic [IRQ_W-1:0] irq_clear;

    // instruction decode; only taken when no second word is pending
    assign accept = issue && (state_reg == ST_IDLE);
    assign is_conv = accept && (instr[15:8] == OP_STCXJ);
    assign is_store_exponent_op = accept && (instr[15:8] == OP_STORE_EXPONENT_OP);
    assign is_store_float_status_op = accept && (instr[15:6] == OP_STORE_FLOAT_STATUS_OP);
    assign is_store_exception_info_op = accept && (instr[15:6] == OP_STORE_EXCEPTION_INFO_OP);
    assign dst_short = (instr[5:3] == 3'b000) || (instr[5:0] == DST_IMMEDIATE);

    // float to integer conversion, single cycle
    always_comb begin
        acc_eff = acc_in;
        if (!fps_reg[FPS_FD]) begin
            acc_eff.frac[31:0] = 32'h0000_0000;
        end
        mant = {1'b1, acc_eff.frac};
        shift_amt = SHIFT_BASE - acc_eff.exp;
        // a plain right shift drops the fraction, which chops toward zero; chop_mode_bit is not consulted
        shifted = mant >> shift_amt;
        limit = fps_reg[FPS_FL] ? LONG_LIMIT : INT_LIMIT;
        mag = 33'h0_0000_0000;
        oor = 1'b0;
        if (acc_eff.exp > EXP_INT_MAX) begin
            oor = 1'b1;
        end else if (acc_eff.exp > EXP_INT_MIN) begin
            mag = {1'b0, shifted[31:0]};
            // negative side reaches one further than the positive limit
            oor = acc_eff.sign ? (mag > (limit + ONE_33)) : (mag > limit);
        end
        if (oor) begin
            conv_val = 32'h0000_0000;
        end else if (acc_eff.sign) begin
            conv_val = 32'h0000_0000 - mag[31:0];
        end else begin
            conv_val = mag[31:0];
        end
    end

    assign conv_neg = conv_val[31];
    assign exp_val = {8'h00, acc_in.exp} - EXP_BIAS;
    assign exp_neg = exp_val[15];

    always_comb begin
        fps_stored = fps_reg;
        fps_stored[FPS_HOLE_HI] = 1'b0;
        fps_stored[FPS_HOLE_LO] = 1'b0;
        if (!config_reg[CFG_MAINT_IMPL]) begin
            fps_stored[FPS_FMM] = 1'b0;
        end
    end

    // destination word sequencer; a pending second word always follows the first with no gap
    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            st_word_reg <= '0;
            pend_data_reg <= 16'h0000;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    st_word_reg <= '0;
                    if (is_conv) begin
                        st_word_reg.valid <= 1'b1;
                        st_word_reg.offset <= WORD_OFFSET_FIRST;
                        if (fps_reg[FPS_FL]) begin
                            st_word_reg.data <= conv_val[31:16];
                            st_word_reg.last <= dst_short;
                            pend_data_reg <= conv_val[15:0];
                            if (!dst_short) begin
                                state_reg <= ST_SECOND;
                            end
                        end else begin
                            st_word_reg.data <= conv_val[15:0];
                            st_word_reg.last <= 1'b1;
                        end
                    end else if (is_store_exponent_op) begin
                        st_word_reg.valid <= 1'b1;
                        st_word_reg.last <= 1'b1;
                        st_word_reg.offset <= WORD_OFFSET_FIRST;
                        st_word_reg.data <= exp_val;
                    end else if (is_store_float_status_op) begin
                        st_word_reg.valid <= 1'b1;
                        st_word_reg.last <= 1'b1;
                        st_word_reg.offset <= WORD_OFFSET_FIRST;
                        st_word_reg.data <= fps_stored;
                    end else if (is_store_exception_info_op) begin
                        st_word_reg.valid <= 1'b1;
                        st_word_reg.offset <= WORD_OFFSET_FIRST;
                        st_word_reg.data <= fec_reg;
                        st_word_reg.last <= dst_short;
                        pend_data_reg <= fea_reg;
                        if (!dst_short) begin
                            state_reg <= ST_SECOND;
                        end
                    end
                end
                ST_SECOND: begin
                    st_word_reg.valid <= 1'b1;
                    st_word_reg.last <= 1'b1;
                    st_word_reg.offset <= WORD_OFFSET_NEXT;
                    st_word_reg.data <= pend_data_reg;
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                    st_word_reg <= '0;
                end
            endcase
        end
    end

    // apb handshake: pready comes one cycle into the access phase
    assign apb_setup = psel && penable && !pready_reg;
    assign apb_take = psel && penable && pready_reg;
    assign apb_wr = apb_take && pwrite;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= apb_setup;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
            if (apb_setup) begin
                if (paddr == ADDR_FPS) begin
                    prdata_reg <= {16'h0000, fps_reg};
                end else if (paddr == ADDR_FEC) begin
                    prdata_reg <= {16'h0000, fec_reg};
                end else if (paddr == ADDR_FEA) begin
                    prdata_reg <= {16'h0000, fea_reg};
                end else if (paddr == ADDR_IRQ_STATUS) begin
                    prdata_reg <= {29'h0000_0000, irq_status_reg};
                end else if (paddr == ADDR_IRQ_ENABLE) begin
                    prdata_reg <= {29'h0000_0000, irq_enable_reg};
                end else if (paddr == ADDR_IRQ_CLEAR) begin
                    prdata_reg <= 32'h0000_0000;
                end else if (paddr == ADDR_CONFIG) begin
                    prdata_reg <= {16'h0000, config_reg};
                end else begin
                    pslverr_reg <= 1'b1;
                end
            end
        end
    end

    // status register; instruction flag updates win over a software write in the same cycle
    always_ff @(posedge clock) begin
        if (!nrst) begin
            fps_reg <= FPS_RESET;
        end else begin
            if (apb_wr && (paddr == ADDR_FPS)) begin
                fps_reg <= pwdata[15:0];
            end
            if (is_conv) begin
                fps_reg[FPS_FC] <= oor;
                fps_reg[FPS_FV] <= 1'b0;
                fps_reg[FPS_FZ] <= (conv_val == 32'h0000_0000);
                fps_reg[FPS_FN] <= conv_neg;
            end else if (is_store_exponent_op) begin
                fps_reg[FPS_FC] <= 1'b0;
                fps_reg[FPS_FV] <= 1'b0;
                fps_reg[FPS_FZ] <= (exp_val == 16'h0000);
                fps_reg[FPS_FN] <= exp_neg;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            cc_out_reg <= '0;
            cc_valid_reg <= 1'b0;
        end else begin
            cc_valid_reg <= is_conv || is_store_exponent_op;
            if (is_conv) begin
                cc_out_reg <= '{n: conv_neg, z: (conv_val == 32'h0000_0000), v: 1'b0, c: oor};
            end else if (is_store_exponent_op) begin
                cc_out_reg <= '{n: exp_neg, z: (exp_val == 16'h0000), v: 1'b0, c: 1'b0};
            end
        end
    end

    // trap: only conversion failure can trap here; the undefined-value trap is never taken
    always_ff @(posedge clock) begin
        if (!nrst) begin
            fp_trap_reg <= 1'b0;
            fec_reg <= FEC_RESET;
            fea_reg <= FEA_RESET;
        end else begin
            fp_trap_reg <= is_conv && oor && fps_reg[FPS_FIC];
            if (is_conv && oor && fps_reg[FPS_FIC]) begin
                fec_reg <= FEC_CONVERT_FAIL;
                fea_reg <= instr_addr;
            end else begin
                if (apb_wr && (paddr == ADDR_FEC)) begin
                    fec_reg <= pwdata[15:0];
                end
                if (apb_wr && (paddr == ADDR_FEA)) begin
                    fea_reg <= pwdata[15:0];
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            config_reg <= CONFIG_RESET;
        end else if (apb_wr && (paddr == ADDR_CONFIG)) begin
            config_reg <= pwdata[15:0];
        end
    end

    // interrupts: a set in the clearing cycle survives
    assign irq_events = {st_word_reg.valid && st_word_reg.last, is_conv && oor && fps_reg[FPS_FIC], is_conv && oor};
    assign irq_clear = (apb_wr && (paddr == ADDR_IRQ_CLEAR)) ? pwdata[IRQ_W-1:0] : '0;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            irq_status_reg <= '0;
            irq_enable_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_events;
            if (apb_wr && (paddr == ADDR_IRQ_ENABLE)) begin
                irq_enable_reg <= pwdata[IRQ_W-1:0];
            end
            irq_reg <= |(irq_status_reg & irq_enable_reg);
        end
    end

    assign st_word = st_word_reg;
    assign cc_out = cc_out_reg;
    assign cc_valid = cc_valid_reg;
    assign busy = (state_reg == ST_SECOND);
    assign fp_trap = fp_trap_reg;
    assign irq = irq_reg;
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    property p_oor_zero;
        is_conv && oor |=> st_word_reg.valid && (st_word_reg.data == 16'h0000) && fps_reg[FPS_FC] && cc_out_reg.c;
    endproperty
    a_oor_zero: assert property (p_oor_zero) else $error("out-of-range store not zero with carry");

    property p_int_limit;
        is_conv && !fps_reg[FPS_FL] && !acc_eff.sign && (mag > INT_LIMIT) |=> fps_reg[FPS_FC];
    endproperty
    a_int_limit: assert property (p_int_limit) else $error("16-bit limit not enforced");

    property p_conv_flags;
        is_conv |=> !fps_reg[FPS_FV] && cc_valid_reg && (fps_reg[FPS_FN] == $past(conv_neg));
    endproperty
    a_conv_flags: assert property (p_conv_flags) else $error("conversion flags wrong");

    property p_long_short;
        is_conv && fps_reg[FPS_FL] && dst_short |=> st_word_reg.valid && st_word_reg.last ##1 !st_word_reg.valid;
    endproperty
    a_long_short: assert property (p_long_short) else $error("short long store wrote two words");

    property p_trap;
        is_conv && oor && fps_reg[FPS_FIC] |=> fp_trap_reg && (fec_reg == FEC_CONVERT_FAIL);
    endproperty
    a_trap: assert property (p_trap) else $error("conversion failure trap missing");

    property p_store_exponent_op;
        is_store_exponent_op |=> st_word_reg.valid && (st_word_reg.data == $past(exp_val)) && (st_word_reg.offset == 2'h0);
    endproperty
    a_store_exponent_op: assert property (p_store_exponent_op) else $error("store exponent value wrong");

    property p_store_exponent_op_flags;
        is_store_exponent_op |=> !fps_reg[FPS_FC] && !fps_reg[FPS_FV] && (fps_reg[FPS_FN] == $past(exp_neg)) && !fp_trap_reg;
    endproperty
    a_store_exponent_op_flags: assert property (p_store_exponent_op_flags) else $error("store exponent flags wrong");

    property p_store_float_status_op;
        is_store_float_status_op |=> st_word_reg.last && (st_word_reg.data[13:12] == 2'b00);
    endproperty
    a_store_float_status_op: assert property (p_store_float_status_op) else $error("status holes not zero");

    property p_store_exception_info_op;
        is_store_exception_info_op && !dst_short |=> (st_word_reg.offset == 2'h0) ##1
            st_word_reg.valid && (st_word_reg.offset == 2'h2) && (st_word_reg.data == $past(fea_reg, 2));
    endproperty
    a_store_exception_info_op: assert property (p_store_exception_info_op) else $error("exception address word wrong");

    property p_store_exception_info_op_short;
        is_store_exception_info_op && dst_short |=> st_word_reg.last && (st_word_reg.data == $past(fec_reg));
    endproperty
    a_store_exception_info_op_short: assert property (p_store_exception_info_op_short) else $error("short exception store wrong");

endmodule

// ---- dv/core_model.sv ----
// host core model: issues store instructions and records the destination words
module core_model
    import fpsc_pkg::*;
(
    // clock
    input wire logic clock,
    // instruction to the unit
    output logic issue,
    output logic [15:0] instr,
    output logic [15:0] instr_addr,
    output acc_t acc_in,
    // results from the unit
    input wire store_word_t st_word,
    input wire logic fp_trap
);
    timeunit 1ns;
    timeprecision 1ps;

    store_word_t words[$];
    int trap_count = 0;

    initial begin
        issue = 1'b0;
        instr = 16'h0000;
        instr_addr = 16'h0000;
        acc_in = '0;
    end

    always @(posedge clock) begin
        if (st_word.valid === 1'b1) begin
            words.push_back(st_word);
        end
        if (fp_trap === 1'b1) begin
            trap_count++;
        end
    end

    // call right after a rising edge; returns at the edge that takes the request
    task automatic send(input logic [15:0] ins, input logic [15:0] ia, input acc_t a);
        issue <= 1'b1;
        instr <= ins;
        instr_addr <= ia;
        acc_in <= a;
        @(posedge clock);
    endtask

    // operand lines turn to inverted garbage so a stale value is never trusted
    task automatic release_bus();
        issue <= 1'b0;
        instr <= ~instr;
        instr_addr <= ~instr_addr;
        acc_in <= ~acc_in;
    endtask
endmodule

// ---- dv/tb.sv ----
// self-checking bench for the floating store/convert unit
`define CHK(nm, e, g) \
    begin \
        total_checks++; \
        if ((g) !== (e)) begin \
            fails++; \
            $display("Error %s expected %h seen %h", nm, e, g); \
        end \
    end

module tb
    import fpsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock, nrst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic issue, cc_valid, busy, fp_trap, irq, err;
    logic [15:0] instr, instr_addr;
    acc_t acc_in;
    store_word_t st_word;
    cc_t cc_out;
    int fails = 0;
    int total_checks = 0;
    int t0;
    int busy_count = 0;
    int ccv_count = 0;

    // pulse counters for the one-cycle outputs, sampled at each edge
    always @(posedge clock) begin
        if (busy === 1'b1) begin
            busy_count++;
        end
        if (cc_valid === 1'b1) begin
            ccv_count++;
        end
    end

    localparam logic [15:0] CVT_MEM = {OP_STCXJ, 2'h0, 6'h09};
    localparam logic [15:0] CVT_REG = {OP_STCXJ, 2'h1, 6'h01};
    localparam logic [15:0] CVT_IMM = {OP_STCXJ, 2'h0, DST_IMMEDIATE};
    localparam logic [15:0] EXP_MEM = {OP_STORE_EXPONENT_OP, 2'h2, 6'h09};
    localparam logic [15:0] FPS_MEM = {OP_STORE_FLOAT_STATUS_OP, 6'h09};
    localparam logic [15:0] ST_MEM = {OP_STORE_EXCEPTION_INFO_OP, 6'h09};
    localparam logic [15:0] ST_REG = {OP_STORE_EXCEPTION_INFO_OP, 6'h02};

    fp_store_convert_unit i_fp_store_convert_unit (
        .clock(clock), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .issue(issue), .instr(instr), .instr_addr(instr_addr), .acc_in(acc_in),
        .st_word(st_word), .cc_out(cc_out), .cc_valid(cc_valid), .busy(busy),
        .fp_trap(fp_trap), .irq(irq)
    );

    core_model i_core_model (
        .clock(clock), .issue(issue), .instr(instr), .instr_addr(instr_addr),
        .acc_in(acc_in), .st_word(st_word), .fp_trap(fp_trap)
    );

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    function automatic acc_t mk(input logic s, input logic [7:0] e, input logic [54:0] f);
        mk = '{sign: s, exp: e, frac: f};
    endfunction

    // one apb transfer; the idle edge after release keeps strobes from being driven twice at once
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (pready !== 1'b1) begin
            fails++;
            finish_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        apb(1'b1, a, {16'h0000, d});
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(nm, e, rd)
        `CHK("slave error", 1'b0, err)
    endtask

    task automatic run(input logic [15:0] ins, input logic [15:0] ia, input acc_t a, input int nw,
        input logic [15:0] w0, input logic [15:0] w1, input logic [3:0] cc);
        int b0;
        int v0;
        b0 = busy_count;
        v0 = ccv_count;
        i_core_model.words.delete();
        i_core_model.send(ins, ia, a);
        i_core_model.release_bus();
        repeat (4) @(posedge clock);
        `CHK("word count", nw, i_core_model.words.size())
        `CHK("busy cycles", nw - 1, busy_count - b0)
        `CHK("cc valid pulses", ((ins[15:8] == OP_STORE_EXPONENT_OP || ins[15:8] == OP_STCXJ) ? 1 : 0), ccv_count - v0)
        if (nw > 0 && i_core_model.words.size() == nw)
            `CHK("first word", {1'b1, nw == 1, WORD_OFFSET_FIRST, w0}, i_core_model.words[0])
        if (nw > 1 && i_core_model.words.size() == nw)
            `CHK("second word", {1'b1, 1'b1, WORD_OFFSET_NEXT, w1}, i_core_model.words[1])
        if (ins[15:8] == OP_STORE_EXPONENT_OP || ins[15:8] == OP_STCXJ)
            `CHK("condition codes", cc, cc_out)
    endtask

    initial begin
        #1000000;
        fails++;
        finish_test();
    end

    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        rdchk("fps reset", ADDR_FPS, 32'h0000_0000);
        apb(1'b0, 8'h1C, 32'h0000_0000);
        `CHK("unmapped error", 1'b1, err)
        `CHK("unmapped data", 32'h0000_0000, rd)
        run(CVT_MEM, 16'h0100, mk(1'b0, 8'h83, 55'h30000000000000), 1, 16'h0005, 16'h0, 4'b0000);
        run(CVT_MEM, 16'h0100, mk(1'b1, 8'h83, 55'h30000000000000), 1, 16'hFFFB, 16'h0, 4'b1000);
        run(CVT_MEM, 16'h0100, mk(1'b0, 8'h8F, 55'h7FFE0000000000), 1, 16'h7FFF, 16'h0, 4'b0000);
        run(CVT_MEM, 16'h0100, mk(1'b0, 8'h90, 55'h0), 1, 16'h0000, 16'h0, 4'b0101);
        rdchk("fps flags", ADDR_FPS, 32'h0000_0005);
        wr(ADDR_FPS, 16'h0800);
        t0 = i_core_model.trap_count;
        run(CVT_MEM, 16'h0100, mk(1'b1, 8'h00, 55'h0), 1, 16'h0000, 16'h0, 4'b0100);
        `CHK("minus zero trap", t0, i_core_model.trap_count)
        wr(ADDR_FPS, 16'h0040);
        run(CVT_MEM, 16'h0100, mk(1'b0, 8'h9F, 55'h2000000), 2, 16'h4000, 16'h0000, 4'b0000);
        wr(ADDR_FPS, 16'h00C0);
        run(CVT_MEM, 16'h0100, mk(1'b0, 8'h9F, 55'h2000000), 2, 16'h4000, 16'h0001, 4'b0000);
        run(CVT_MEM, 16'h0100, mk(1'b1, 8'h9F, 55'h2000000), 2, 16'hBFFF, 16'hFFFF, 4'b1000);
        run(CVT_REG, 16'h0100, mk(1'b0, 8'h9F, 55'h2000000), 1, 16'h4000, 16'h0, 4'b0000);
        run(CVT_IMM, 16'h0100, mk(1'b0, 8'h9F, 55'h2000000), 1, 16'h4000, 16'h0, 4'b0000);
        wr(ADDR_FPS, 16'h0140);
        t0 = i_core_model.trap_count;
        run(CVT_MEM, 16'h2468, mk(1'b0, 8'hA1, 55'h0), 2, 16'h0000, 16'h0000, 4'b0101);
        `CHK("convert trap", t0 + 1, i_core_model.trap_count)
        rdchk("fec", ADDR_FEC, {16'h0000, FEC_CONVERT_FAIL});
        rdchk("fea", ADDR_FEA, 32'h0000_2468);
        // saved code and address are read back only right after a trapping conversion
        run(ST_MEM, 16'h0200, mk(1'b0, 8'h00, 55'h0), 2, FEC_CONVERT_FAIL, 16'h2468, 4'h0);
        run(ST_REG, 16'h0200, mk(1'b0, 8'h00, 55'h0), 1, FEC_CONVERT_FAIL, 16'h0, 4'h0);
        wr(ADDR_FPS, 16'h0800);
        t0 = i_core_model.trap_count;
        i_core_model.words.delete();
        i_core_model.send(EXP_MEM, 16'h0300, mk(1'b1, 8'h83, 55'h0));
        i_core_model.send(EXP_MEM, 16'h0300, mk(1'b0, 8'h7E, 55'h0));
        i_core_model.release_bus();
        repeat (4) @(posedge clock);
        `CHK("exponent first", 16'h0003, i_core_model.words[0].data)
        `CHK("exponent second", 16'hFFFE, i_core_model.words[1].data)
        `CHK("exponent cc", 4'b1000, cc_out)
        run(EXP_MEM, 16'h0300, mk(1'b1, 8'h80, 55'h0), 1, 16'h0000, 16'h0, 4'b0100);
        run(EXP_MEM, 16'h0300, mk(1'b1, 8'h00, 55'h0), 1, 16'hFF80, 16'h0, 4'b1000);
        `CHK("exponent trap", t0, i_core_model.trap_count)
        wr(ADDR_CONFIG, 16'h0001);
        wr(ADDR_FPS, 16'h393F);
        run(FPS_MEM, 16'h0400, mk(1'b0, 8'h00, 55'h0), 1, 16'h093F, 16'h0, 4'h0);
        wr(ADDR_CONFIG, 16'h0000);
        run(FPS_MEM, 16'h0400, mk(1'b0, 8'h00, 55'h0), 1, 16'h092F, 16'h0, 4'h0);
        rdchk("irq status", ADDR_IRQ_STATUS, 32'h0000_0007);
        `CHK("irq masked", 1'b0, irq)
        wr(ADDR_IRQ_ENABLE, 16'h0002);
        repeat (2) @(posedge clock);
        `CHK("irq raised", 1'b1, irq)
        rdchk("irq enable", ADDR_IRQ_ENABLE, 32'h0000_0002);
        wr(ADDR_IRQ_CLEAR, 16'h0002);
        repeat (2) @(posedge clock);
        `CHK("irq cleared", 1'b0, irq)
        rdchk("irq after clear", ADDR_IRQ_STATUS, 32'h0000_0005);
        rdchk("clear reads zero", ADDR_IRQ_CLEAR, 32'h0000_0000);
        finish_test();
    end
endmodule
